// file: sdc_defines.vh
// constants shared by the sdram command arbiter and data path
`ifndef SDC_DEFINES_VH
`define SDC_DEFINES_VH

`define SDC_CMD_NOP 3'h0
`define SDC_CMD_RDA 3'h1
`define SDC_CMD_WRA 3'h2
`define SDC_CMD_REFRESH 3'h3
`define SDC_CMD_PRECHARGE 3'h4
`define SDC_CMD_LOAD_MODE 3'h5

// sdram bus command as {ras_n, cas_n, we_n}
`define SDC_SD_NOP 3'h7
`define SDC_SD_ACT 3'h3
`define SDC_SD_RD 3'h5
`define SDC_SD_WR 3'h4
`define SDC_SD_PCH 3'h2
`define SDC_SD_ARF 3'h1
`define SDC_SD_LMR 3'h0

`define SDC_CFG_LAT_LO 0
`define SDC_CFG_LAT_HI 1
`define SDC_CFG_R2C_LO 2
`define SDC_CFG_R2C_HI 3
`define SDC_CFG_RRD_LO 4
`define SDC_CFG_RRD_HI 7
`define SDC_CFG_PAGE_BIT 8
`define SDC_CFG_BL_LO 9
`define SDC_CFG_BL_HI 12
`define SDC_CFG_RESET 13'h1027
`define SDC_RIW_RESET 16'h061A

`define SDC_OFS_CFG 8'h00
`define SDC_OFS_RIW 8'h04
`define SDC_OFS_STAT 8'h08
`define SDC_RESP_OKAY 2'h0
`define SDC_RESP_SLVERR 2'h2

`define SDC_AP_BIT 10
`define SDC_PCH_LEAD 32'h00000004
`define SDC_SHORT_OP 6'h03
`define SDC_WR_ALIGN 6'h04

`endif

// file: sdc_shift.v
// loadable right shift register used for command timing
module sdc_shift #(
    parameter W = 32
) (
    input wire core_clk_i,
    input wire rstn_i,
    input wire load_i,
    input wire [W-1:0] load_val_i,
    output wire fire_o
);
    reg [W-1:0] sr_r;

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sr_r <= {W{1'b0}};
        end else if (load_i) begin
            sr_r <= load_val_i;
        end else begin
            sr_r <= sr_r >> 1;
        end
    end

    assign fire_o = sr_r[0];
endmodule // sdc_shift

// file: sdc_rd_pipe.v
// read data register pipeline with selectable depth
module sdc_rd_pipe #(
    parameter W = 33,
    parameter STAGES = 2
) (
    input wire core_clk_i,
    input wire rstn_i,
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    genvar g;
    generate
        if (STAGES == 0) begin : g_none
            // zero stages: output is combinational from the pins
            assign q_o = d_i;
        end else begin : g_pipe
            reg [W-1:0] st_r [0:STAGES-1];
            for (g = 0; g < STAGES; g = g + 1) begin : g_st
                always @(posedge core_clk_i or negedge rstn_i) begin
                    if (!rstn_i) begin
                        st_r[g] <= {W{1'b0}};
                    end else if (g == 0) begin
                        st_r[g] <= d_i;
                    end else begin
                        st_r[g] <= st_r[g-1];
                    end
                end
            end
            assign q_o = st_r[STAGES-1];
        end
    endgenerate
endmodule // sdc_rd_pipe

// file: sdc_top.v
// sdram command arbiter, address multiplexer and data path with axi4-lite config
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`include "sdc_defines.vh"
module sdc_top #(
    parameter DW = 32,
    parameter COL_W = 8,
    parameter ROW_W = 12,
    parameter BA_W = 2,
    parameter AXI_AW = 8,
    parameter RD_STAGES = 2
) (
    input wire core_clk_i,
    input wire rstn_i,
    input wire [2:0] host_cmd_i,
    input wire [COL_W+ROW_W+BA_W-1:0] host_addr_i,
    input wire [DW-1:0] host_write_data_i,
    output wire command_acknowledge_o,
    output wire [DW-1:0] host_read_data_o,
    output wire host_read_valid_o,
    output wire sd_cs_n_o,
    output wire sd_ras_n_o,
    output wire sd_cas_n_o,
    output wire sd_we_n_o,
    output wire [11:0] sd_addr_o,
    output wire [BA_W-1:0] sd_ba_o,
    output wire [DW-1:0] sd_dq_o,
    output wire sd_dq_oe_o,
    input wire [DW-1:0] sd_dq_i,
    input wire [AXI_AW-1:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output wire [1:0] s_axi_bresp_o,
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [AXI_AW-1:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i
);
    reg [12:0] cfg_r;
    reg [15:0] riw_r;
    reg [15:0] rcnt_r;
    reg rflag_r;
    reg ack_r;
    reg [2:0] sdcmd_r;
    reg [11:0] sdaddr_r;
    reg [BA_W-1:0] sdba_r;
    reg [COL_W-1:0] col_r;
    reg [BA_W-1:0] bank_r;
    reg is_wr_r;
    reg page_open_r;
    reg pch_pend_r;
    reg rd_act_r;
    reg wr_act_r;
    reg [3:0] bl_cnt_r;
    reg [2:0] rv_r;
    reg [DW-1:0] wd1_r;
    reg [DW-1:0] wd2_r;
    reg aw_got_r;
    reg w_got_r;
    reg [AXI_AW-1:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg awready_r;
    reg wready_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg arready_r;
    reg rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0] rresp_r;

    wire [1:0] lat_f = cfg_r[`SDC_CFG_LAT_HI:`SDC_CFG_LAT_LO];
    wire [1:0] r2c_f = cfg_r[`SDC_CFG_R2C_HI:`SDC_CFG_R2C_LO];
    wire [3:0] rrd_f = cfg_r[`SDC_CFG_RRD_HI:`SDC_CFG_RRD_LO];
    wire pg_on = cfg_r[`SDC_CFG_PAGE_BIT];
    wire [3:0] bl_f = cfg_r[`SDC_CFG_BL_HI:`SDC_CFG_BL_LO];
    // zero latency, row-to-column and burst settings would break the shift timing, so they act as one
    wire [5:0] lat_e = (lat_f == 2'h0) ? 6'h01 : {4'h0, lat_f};
    wire [5:0] r2c_e = (r2c_f == 2'h0) ? 6'h01 : {4'h0, r2c_f};
    wire [5:0] bl_e = (bl_f == 4'h0) ? 6'h01 : {2'h0, bl_f};
    wire [5:0] rrd_e = {2'h0, rrd_f};

    wire [COL_W-1:0] h_col = host_addr_i[COL_W-1:0];
    wire [ROW_W-1:0] h_row = host_addr_i[COL_W+ROW_W-1:COL_W];
    wire [BA_W-1:0] h_ba = host_addr_i[COL_W+ROW_W+BA_W-1:COL_W+ROW_W];

    wire row_fire;
    wire col_fire;
    wire dur_busy;
    reg row_load;
    reg col_load;
    reg dur_load;
    reg [31:0] col_val;
    reg [31:0] dur_val;
    reg go_hid;
    reg go_ref;
    reg go_rw;
    reg go_pch;
    reg go_lmr;
    reg [5:0] dly;

    function [31:0] therm;
        input [5:0] n;
        begin
            therm = (32'h00000001 << n) - 32'h00000001;
        end
    endfunction

    // host waits (no ack) while anything runs, including a hidden refresh
    wire idle = !dur_busy && !page_open_r && !pch_pend_r;

    always @* begin
        row_load = 1'b0;
        col_load = 1'b0;
        dur_load = 1'b0;
        col_val = 32'h00000000;
        dur_val = 32'h00000000;
        go_hid = 1'b0;
        go_ref = 1'b0;
        go_rw = 1'b0;
        go_pch = 1'b0;
        go_lmr = 1'b0;
        dly = 6'h00;
        if (row_fire) begin
            // after closing the page, cover the trailing read words
            dur_load = 1'b1;
            dur_val = therm(lat_e + `SDC_SHORT_OP);
        end else if (idle) begin
            if (rflag_r) begin
                go_hid = 1'b1;
                dur_load = 1'b1;
                dur_val = therm(rrd_e + 6'h01);
            end else begin
                case (host_cmd_i)
                    `SDC_CMD_RDA, `SDC_CMD_WRA: begin
                        go_rw = 1'b1;
                        // writes wait for data to cross the two input stages
                        dly = (host_cmd_i == `SDC_CMD_WRA) ? r2c_e + `SDC_WR_ALIGN : r2c_e;
                        col_load = 1'b1;
                        col_val = 32'h00000001 << (dly - 6'h01);
                        dur_load = 1'b1;
                        if (pg_on) begin
                            dur_val = therm(dly + 6'h01);
                        end else begin
                            dur_val = therm(dly + bl_e + lat_e + `SDC_SHORT_OP);
                        end
                    end
                    `SDC_CMD_REFRESH: begin
                        go_ref = 1'b1;
                        dur_load = 1'b1;
                        dur_val = therm(rrd_e + 6'h01);
                    end
                    `SDC_CMD_PRECHARGE: begin
                        go_pch = 1'b1;
                        dur_load = 1'b1;
                        dur_val = therm(`SDC_SHORT_OP);
                    end
                    `SDC_CMD_LOAD_MODE: begin
                        go_lmr = 1'b1;
                        dur_load = 1'b1;
                        dur_val = therm(`SDC_SHORT_OP);
                    end
                    default: begin
                        dly = 6'h00;
                    end
                endcase
            end
        end else if (page_open_r && !dur_busy && !pch_pend_r &&
                     host_cmd_i == `SDC_CMD_PRECHARGE) begin
            row_load = 1'b1;
        end
    end

    // row commands (terminating precharge) positioned by the row shifter
    sdc_shift #(.W(32)) u_row_sr (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .load_i(row_load),
        .load_val_i(`SDC_PCH_LEAD),
        .fire_o(row_fire)
    );
    sdc_shift #(.W(32)) u_col_sr (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .load_i(col_load),
        .load_val_i(col_val),
        .fire_o(col_fire)
    );
    sdc_shift #(.W(32)) u_dur_sr (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .load_i(dur_load),
        .load_val_i(dur_val),
        .fire_o(dur_busy)
    );

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_r <= 1'b0;
            sdcmd_r <= `SDC_SD_NOP;
            sdaddr_r <= 12'h000;
            sdba_r <= {BA_W{1'b0}};
            col_r <= {COL_W{1'b0}};
            bank_r <= {BA_W{1'b0}};
            is_wr_r <= 1'b0;
            page_open_r <= 1'b0;
            pch_pend_r <= 1'b0;
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
            bl_cnt_r <= 4'h0;
        end else begin
            ack_r <= go_ref | go_rw | go_pch | go_lmr | row_fire;
            sdcmd_r <= `SDC_SD_NOP;
            if (go_hid || go_ref) begin
                sdcmd_r <= `SDC_SD_ARF;
            end
            if (go_rw) begin
                sdcmd_r <= `SDC_SD_ACT;
                sdaddr_r <= h_row;
                sdba_r <= h_ba;
                col_r <= h_col;
                bank_r <= h_ba;
                is_wr_r <= (host_cmd_i == `SDC_CMD_WRA);
                page_open_r <= pg_on;
            end
            if (go_pch) begin
                sdcmd_r <= `SDC_SD_PCH;
                sdaddr_r <= 12'h400;
            end
            if (go_lmr) begin
                sdcmd_r <= `SDC_SD_LMR;
                sdaddr_r <= host_addr_i[11:0];
                sdba_r <= {BA_W{1'b0}};
            end
            if (row_load) begin
                pch_pend_r <= 1'b1;
            end
            if (col_fire) begin
                sdcmd_r <= is_wr_r ? `SDC_SD_WR : `SDC_SD_RD;
                sdaddr_r <= {{(12-COL_W){1'b0}}, col_r};
                sdaddr_r[`SDC_AP_BIT] <= !pg_on;
                sdba_r <= bank_r;
                rd_act_r <= !is_wr_r;
                wr_act_r <= is_wr_r;
                bl_cnt_r <= bl_e[3:0];
            end else if (row_fire) begin
                sdcmd_r <= `SDC_SD_PCH;
                sdaddr_r <= 12'h400;
                page_open_r <= 1'b0;
                pch_pend_r <= 1'b0;
                rd_act_r <= 1'b0;
                wr_act_r <= 1'b0;
            end else if ((rd_act_r || wr_act_r) && !page_open_r) begin
                // normal mode burst length ends the data window
                bl_cnt_r <= bl_cnt_r - 4'h1;
                if (bl_cnt_r == 4'h1) begin
                    rd_act_r <= 1'b0;
                    wr_act_r <= 1'b0;
                end
            end
        end
    end

    // refresh interval counter; page mode freezes requests
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rcnt_r <= `SDC_RIW_RESET;
            rflag_r <= 1'b0;
        end else begin
            if (go_hid) begin
                rcnt_r <= riw_r;
            end else if (rcnt_r != 16'h0000) begin
                rcnt_r <= rcnt_r - 16'h0001;
            end
            if (rcnt_r == 16'h0000 && !pg_on && !go_hid) begin
                rflag_r <= 1'b1;
            end else if (go_hid || pg_on) begin
                rflag_r <= 1'b0;
            end
        end
    end

    // write data: two stages so the pin data meets the write command
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wd1_r <= {DW{1'b0}};
            wd2_r <= {DW{1'b0}};
            rv_r <= 3'h0;
        end else begin
            wd1_r <= host_write_data_i;
            wd2_r <= wd1_r;
            rv_r <= {rv_r[1:0], rd_act_r};
        end
    end

    wire rv_sel = rv_r[lat_e[1:0] - 2'h1];
    wire [DW:0] rp_q;
    sdc_rd_pipe #(.W(DW + 1), .STAGES(RD_STAGES)) u_rd_pipe (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .d_i({rv_sel, sd_dq_i}),
        .q_o(rp_q)
    );

    // axi4-lite slave: one write and one read at a time
    wire [AXI_AW-1:0] ofs_cfg = `SDC_OFS_CFG;
    wire [AXI_AW-1:0] ofs_riw = `SDC_OFS_RIW;
    wire [AXI_AW-1:0] ofs_stat = `SDC_OFS_STAT;
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_r <= `SDC_CFG_RESET;
            riw_r <= `SDC_RIW_RESET;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= {AXI_AW{1'b0}};
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= `SDC_RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `SDC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && awready_r) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr_i;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid_i && wready_r) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
                wready_r <= 1'b0;
            end
            if (aw_got_r && w_got_r && !bvalid_r) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= `SDC_RESP_OKAY;
                if (awaddr_r == ofs_cfg) begin
                    if (wstrb_r[0]) cfg_r[7:0] <= wdata_r[7:0];
                    if (wstrb_r[1]) cfg_r[12:8] <= wdata_r[12:8];
                end else if (awaddr_r == ofs_riw) begin
                    if (wstrb_r[0]) riw_r[7:0] <= wdata_r[7:0];
                    if (wstrb_r[1]) riw_r[15:8] <= wdata_r[15:8];
                end else if (awaddr_r != ofs_stat) begin
                    bresp_r <= `SDC_RESP_SLVERR;
                end
            end
            if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
            if (s_axi_arvalid_i && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rresp_r <= `SDC_RESP_OKAY;
                if (s_axi_araddr_i == ofs_cfg) begin
                    rdata_r <= {19'h00000, cfg_r};
                end else if (s_axi_araddr_i == ofs_riw) begin
                    rdata_r <= {16'h0000, riw_r};
                end else if (s_axi_araddr_i == ofs_stat) begin
                    rdata_r <= {rcnt_r, 12'h000, rflag_r, pch_pend_r, page_open_r, dur_busy};
                end else begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= `SDC_RESP_SLVERR;
                end
            end
            if (rvalid_r && s_axi_rready_i) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    assign command_acknowledge_o = ack_r;
    assign host_read_data_o = rp_q[DW-1:0];
    assign host_read_valid_o = rp_q[DW];
    assign sd_cs_n_o = 1'b0;
    assign sd_ras_n_o = sdcmd_r[2];
    assign sd_cas_n_o = sdcmd_r[1];
    assign sd_we_n_o = sdcmd_r[0];
    assign sd_addr_o = sdaddr_r;
    assign sd_ba_o = sdba_r;
    assign sd_dq_o = wd2_r;
    assign sd_dq_oe_o = wr_act_r;
    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o = wready_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;
    assign s_axi_rvalid_o = rvalid_r;
endmodule // sdc_top

// file: sdc_monitor.sv
// concurrent checks on the sdram arbiter top-level ports
`include "sdc_defines.vh"
module sdc_monitor (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [2:0] host_cmd_i,
    input wire logic [21:0] host_addr_i,
    input wire logic [31:0] host_write_data_i,
    input wire logic command_acknowledge_o,
    input wire logic [31:0] host_read_data_o,
    input wire logic host_read_valid_o,
    input wire logic sd_ras_n_o,
    input wire logic sd_cas_n_o,
    input wire logic sd_we_n_o,
    input wire logic [11:0] sd_addr_o,
    input wire logic [31:0] sd_dq_o,
    input wire logic sd_dq_oe_o,
    input wire logic [31:0] sd_dq_i
);
    wire [2:0] sd_cmd = {sd_ras_n_o, sd_cas_n_o, sd_we_n_o};
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_hidden_arf;
        sd_cmd == `SDC_SD_ARF && !command_acknowledge_o;
    endsequence
    sequence s_held_off;
        !command_acknowledge_o [*2];
    endsequence
    property p_refresh_holds; s_hidden_arf |=> s_held_off; endproperty
    property p_ack_cause; command_acknowledge_o |-> $past(host_cmd_i) != `SDC_CMD_NOP; endproperty
    property p_act_on_ack;
        command_acknowledge_o && host_cmd_i inside {`SDC_CMD_RDA, `SDC_CMD_WRA}
            |-> sd_cmd == `SDC_SD_ACT;
    endproperty
    property p_act_row; sd_cmd == `SDC_SD_ACT |-> sd_addr_o == host_addr_i[19:8]; endproperty
    property p_pch_ack;
        command_acknowledge_o && host_cmd_i == `SDC_CMD_PRECHARGE |-> sd_cmd == `SDC_SD_PCH;
    endproperty
    property p_oe_start; $rose(sd_dq_oe_o) |-> sd_cmd == `SDC_SD_WR; endproperty
    property p_wr_pipe; sd_dq_oe_o |-> sd_dq_o == $past(host_write_data_i, 2); endproperty
    property p_rd_pipe; host_read_valid_o |-> host_read_data_o == $past(sd_dq_i, 2); endproperty
    property p_rd_start; sd_cmd == `SDC_SD_RD |-> ##[3:5] host_read_valid_o; endproperty
    a_refresh_holds: assert property (p_refresh_holds)
        else $error("ack inside hidden refresh");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without host command");
    a_act_on_ack: assert property (p_act_on_ack)
        else $error("no activate with ack");
    a_act_row: assert property (p_act_row)
        else $error("activate address not row");
    a_pch_ack: assert property (p_pch_ack)
        else $error("precharge ack without precharge");
    a_oe_start: assert property (p_oe_start)
        else $error("drive enable without write");
    a_wr_pipe: assert property (p_wr_pipe)
        else $error("write data not two stages");
    a_rd_pipe: assert property (p_rd_pipe)
        else $error("read data not two stages");
    a_rd_start: assert property (p_rd_start)
        else $error("read words late");
endmodule // sdc_monitor

bind sdc_top sdc_monitor mon_u (.core_clk_i, .rstn_i, .host_cmd_i, .host_addr_i,
    .host_write_data_i, .command_acknowledge_o, .host_read_data_o, .host_read_valid_o,
    .sd_ras_n_o, .sd_cas_n_o, .sd_we_n_o, .sd_addr_o, .sd_dq_o, .sd_dq_oe_o, .sd_dq_i);

// file: sdc_sdram_model.sv
// sdram read-side model: bursts words after cas latency
`include "sdc_defines.vh"
module sdc_sdram_model #(
    parameter int CAS_LAT = 3,
    parameter int BL = 8
) (
    input wire logic core_clk_i,
    input wire logic [2:0] cmd_i,
    input wire logic [7:0] col_i,
    input wire logic page_i,
    output logic [31:0] dq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] lat_r = 3'h0;
    logic [8:0] left_r = 9'h0;
    logic [7:0] col_r = 8'h0;
    initial dq_o = 32'h0;
    always @(posedge core_clk_i) begin
        // released bus never repeats the last word
        dq_o <= ~dq_o;
        if (lat_r > 3'h1) lat_r <= lat_r - 3'h1;
        if (lat_r == 3'h1 && left_r != 9'h0) begin
            dq_o <= 32'hD0000000 + {24'h0, col_r};
            col_r <= col_r + 8'h1;
            left_r <= left_r - 9'h1;
        end
        if (cmd_i == `SDC_SD_RD) begin
            lat_r <= 3'(CAS_LAT - 1);
            left_r <= page_i ? 9'h100 : 9'(BL);
            col_r <= col_i;
        end
        // precharge lets cas latency minus one words drain
        if (cmd_i == `SDC_SD_PCH && left_r > 9'(CAS_LAT - 1)) left_r <= 9'(CAS_LAT - 1);
    end
endmodule // sdc_sdram_model

// file: sdc_top_bench.sv
// self-checking bench for the sdram command arbiter and data path
`include "sdc_defines.vh"
module sdc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [2:0] host_cmd_i = `SDC_CMD_NOP;
    logic [21:0] host_addr_i = 22'h0;
    logic [31:0] host_write_data_i = 32'hC0000000;
    logic [7:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, page_r = 1'b0;
    wire command_acknowledge_o, host_read_valid_o, sd_ras_n_o, sd_cas_n_o, sd_we_n_o, sd_dq_oe_o;
    wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    wire [31:0] host_read_data_o, sd_dq_o, s_axi_rdata_o, mdl_dq;
    wire [11:0] sd_addr_o;
    wire [1:0] s_axi_bresp_o, s_axi_rresp_o, sd_ba_o;
    wire sd_cs_n_o;
    wire [2:0] sd_cmd = {sd_ras_n_o, sd_cas_n_o, sd_we_n_o};
    wire [31:0] sd_dq_i = sd_dq_oe_o ? sd_dq_o : mdl_dq;
    int fail_count = 0, tests_run = 0, cyc = 0, hid_cnt = 0, vld_cnt = 0, a_cyc, p_cyc;
    sdc_top dut_u (.core_clk_i, .rstn_i, .host_cmd_i, .host_addr_i, .host_write_data_i,
        .command_acknowledge_o, .host_read_data_o, .host_read_valid_o, .sd_cs_n_o,
        .sd_ras_n_o, .sd_cas_n_o, .sd_we_n_o, .sd_addr_o, .sd_ba_o, .sd_dq_o, .sd_dq_oe_o,
        .sd_dq_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i);
    sdc_sdram_model model_u (.core_clk_i(core_clk_i), .cmd_i(sd_cmd), .col_i(sd_addr_o[7:0]),
        .page_i(page_r), .dq_o(mdl_dq));
    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        host_write_data_i <= host_write_data_i + 32'h1; // a new word every clock
        if (sd_cmd == `SDC_SD_ARF && !command_acknowledge_o) hid_cnt <= hid_cnt + 1;
        if (host_read_valid_o) vld_cnt <= vld_cnt + 1;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        @(posedge core_clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        #1;
        while (s_axi_bvalid_o !== 1'b1) begin
            aw = s_axi_awvalid_i && s_axi_awready_o;
            w = s_axi_wvalid_i && s_axi_wready_o;
            @(posedge core_clk_i);
            if (aw) s_axi_awvalid_i <= 1'b0;
            if (w) s_axi_wvalid_i <= 1'b0;
            #1;
        end
        r = s_axi_bresp_o;
        @(posedge core_clk_i);
        s_axi_bready_i <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar;
        @(posedge core_clk_i);
        s_axi_araddr_i <= a;
        {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
        #1;
        while (s_axi_rvalid_o !== 1'b1) begin
            ar = s_axi_arvalid_i && s_axi_arready_o;
            @(posedge core_clk_i);
            if (ar) s_axi_arvalid_i <= 1'b0;
            #1;
        end
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        @(posedge core_clk_i);
        s_axi_rready_i <= 1'b0;
    endtask
    // holds the command until acknowledged, then returns one clock later
    task automatic issue(input logic [2:0] c, input logic [21:0] ad, input logic [2:0] sd);
        @(posedge core_clk_i);
        host_cmd_i <= c;
        host_addr_i <= ad;
        #1;
        p_cyc = cyc;
        while (command_acknowledge_o !== 1'b1) tick(1);
        a_cyc = cyc;
        chk("cmd_at_ack", sd, sd_cmd);
        @(posedge core_clk_i);
        host_cmd_i <= `SDC_CMD_NOP;
        #1;
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(`SDC_OFS_CFG, d, r);
        chk("cfg_reset", 32'h00001027, d);
        axi_rd(`SDC_OFS_RIW, d, r);
        chk("riw_reset", 32'h0000061A, d);
        axi_rd(8'h40, d, r);
        chk("unmapped_rd", `SDC_RESP_SLVERR, r);
        axi_wr(8'h40, 32'hFFFFFFFF, r);
        chk("unmapped_wr", `SDC_RESP_SLVERR, r);
    endtask
    task automatic t_read;
        issue(`SDC_CMD_LOAD_MODE, 22'h000033, `SDC_SD_LMR);
        issue(`SDC_CMD_RDA, 22'h012A35, `SDC_SD_ACT);
        chk("cs_low", 0, sd_cs_n_o);
        chk("rd_cmd", `SDC_SD_RD, sd_cmd);
        chk("rd_col", 32'h435, sd_addr_o);
        tick(4);
        chk("rd_early", 0, host_read_valid_o);
        tick(1);
        chk("rd_first", 1, host_read_valid_o);
        chk("rd_word", 32'hD0000035, host_read_data_o);
    endtask
    task automatic t_write;
        logic [31:0] w0;
        issue(`SDC_CMD_WRA, 22'h2034C7, `SDC_SD_ACT);
        w0 = host_write_data_i + 32'h2;
        tick(4);
        chk("wr_cmd", `SDC_SD_WR, sd_cmd);
        chk("wr_col", 32'h4C7, sd_addr_o);
        chk("wr_bank", 2, sd_ba_o);
        chk("wr_oe", 1, sd_dq_oe_o);
        chk("wr_word", w0, sd_dq_o);
        tick(8);
        chk("wr_oe_end", 0, sd_dq_oe_o);
    endtask
    task automatic t_refresh;
        logic [1:0] r;
        int h;
        axi_wr(`SDC_OFS_RIW, 32'h00000020, r);
        h = 0;
        while (!(sd_cmd == `SDC_SD_ARF && command_acknowledge_o === 1'b0) && h < 2000) begin
            tick(1);
            h++;
        end
        chk("hidden_arf", 1, h < 2000);
        h = cyc;
        issue(`SDC_CMD_RDA, 22'h000100, `SDC_SD_ACT);
        chk("held_off", 1, a_cyc - h >= 3);
        tick(30);
    endtask
    task automatic t_page;
        logic [1:0] r;
        int a0, n, h0, v0;
        axi_wr(`SDC_OFS_CFG, 32'h00001127, r);
        page_r = 1'b1;
        h0 = hid_cnt;
        v0 = vld_cnt;
        issue(`SDC_CMD_RDA, 22'h002210, `SDC_SD_ACT);
        a0 = a_cyc;
        chk("page_col", 32'h010, sd_addr_o);
        tick(5);
        chk("page_first", 1, host_read_valid_o);
        tick(9);
        issue(`SDC_CMD_PRECHARGE, 22'h0, `SDC_SD_PCH);
        chk("pch_lag", 4, a_cyc - p_cyc);
        n = 0;
        while (host_read_valid_o === 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk("page_tail", 4, n);
        chk("page_words", a_cyc - a0 - 1, vld_cnt - v0);
        issue(`SDC_CMD_REFRESH, 22'h0, `SDC_SD_ARF);
        issue(`SDC_CMD_WRA, 22'h1000C0, `SDC_SD_ACT);
        tick(12);
        chk("page_wr_oe", 1, sd_dq_oe_o);
        issue(`SDC_CMD_PRECHARGE, 22'h0, `SDC_SD_PCH);
        chk("wr_pch_lag", 4, a_cyc - p_cyc);
        chk("wr_oe_stop", 0, sd_dq_oe_o);
        tick(100);
        chk("page_no_arf", 0, hid_cnt - h0);
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        tick(1);
        t_regs();
        t_read();
        t_write();
        t_refresh();
        t_page();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fail_count++;
        final_report();
    end
endmodule // sdc_top_bench
